// ---- core/ccb_pkg.sv ----
package ccb_pkg;

    // data path
    localparam int DATA_W = 8;
    localparam int FILE_ADDR_W = 6;
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;

    // instruction select from the decoder, one-hot
    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_CLEAR_ACCUM = 5'h01,
        OP_CLEAR_REG = 5'h02,
        OP_WATCHDOG_CLEAR = 5'h04,
        OP_COMPLEMENT_REG = 5'h08,
        OP_DECIMAL_ADJUST = 5'h10
    } ccb_op_e;

    // destination select of the complement instruction
    localparam logic DEST_ACCUM = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // register map, byte addresses
    localparam logic [BUS_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [BUS_AW-1:0] REG_STAT = 8'h04;
    localparam logic [BUS_AW-1:0] REG_ACCUM = 8'h08;
    localparam logic [BUS_AW-1:0] REG_WDOG = 8'h0C;
    localparam logic [BUS_AW-1:0] REG_PRESC = 8'h10;

    // control fields
    localparam int CTRL_PSA_BIT = 0;
    localparam int CTRL_WDEN_BIT = 1;
    localparam logic CTRL_PSA_RST = 1'b1;
    localparam logic CTRL_WDEN_RST = 1'b1;

    // status fields
    localparam int STAT_ZERO_BIT = 0;
    localparam int STAT_CARRY_BIT = 1;
    localparam int STAT_PWRDN_BIT = 3;
    localparam int STAT_TO_BIT = 4;
    localparam logic TO_RST = 1'b1;
    localparam logic PWRDN_RST = 1'b1;

    // data constants
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONES = 8'hFF;
    localparam logic [DATA_W-1:0] BCD_LOW_FIX = 8'h06;
    localparam logic [DATA_W-1:0] BCD_HIGH_FIX = 8'h60;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [DATA_W-1:0] BCD_BYTE_MAX = 8'h99;

    // watchdog base tick
    localparam int CLK_PERIOD_NS = 20;
    localparam int WDOG_TICK_NS = 1000;
    localparam int WDOG_TICK_CYC = (WDOG_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ---- core/ccb_bcd_adjust.sv ----
`timescale 1ns/1ps
module ccb_bcd_adjust import ccb_pkg::*; (
    // value to correct
    input wire logic [DATA_W-1:0] value,
    input wire logic carryIn,
    input wire logic halfCarryIn,
    // corrected value
    output logic [DATA_W-1:0] result,
    output logic carryOut
);

    logic lowFix;
    logic highFix;

    always_comb begin
        lowFix = halfCarryIn || (value[3:0] > BCD_DIGIT_MAX);
        // high test on the raw value covers the ripple out of the low digit
        highFix = carryIn || (value > BCD_BYTE_MAX);
        result = value + (lowFix ? BCD_LOW_FIX : BYTE_ZERO) + (highFix ? BCD_HIGH_FIX : BYTE_ZERO);
        carryOut = highFix;
    end

endmodule

// ---- core/ccb_exec.sv ----
// What this block does
// - clear-accumulator loads zero into the accumulator and sets the zero flag.
// - clear-register writes zero to the addressed file register and sets zero flag.
// - watchdog-clear resets the watchdog counter to zero.
// - watchdog-clear zeroes the prescaler only when it serves the watchdog.
// - watchdog-clear sets the timeout and powerdown flags, nothing else.
// - complement inverts the addressed file register and sets zero from the result.
// - complement destination 0 goes to accumulator, 1 back to the file register.
// - decimal-adjust corrects the accumulator to packed decimal and updates carry.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module ccb_exec import ccb_pkg::*; #(
    parameter int TICK_CYC = WDOG_TICK_CYC,
    parameter int TICK_W = 8,
    parameter int PRESC_W = 8,
    parameter int WDOG_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // instruction from the decoder
    input wire logic opValid,
    input wire ccb_op_e opCode,
    input wire logic [FILE_ADDR_W-1:0] fileAddr,
    input wire logic destSel,
    input wire logic [DATA_W-1:0] fileRdata,
    input wire logic halfCarry,
    // register bus
    input wire logic [BUS_AW-1:0] regAddr,
    input wire logic [BUS_DW-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [BUS_DW-1:0] regRdata,
    // file register write port
    output logic fileWrEn,
    output logic [FILE_ADDR_W-1:0] fileWaddr,
    output logic [DATA_W-1:0] fileWdata,
    // core state
    output logic [DATA_W-1:0] accumulator,
    output logic zeroFlag,
    output logic carryFlag,
    output logic timeoutFlag,
    output logic powerdownFlag,
    output logic [WDOG_W-1:0] watchdogCount,
    output logic [PRESC_W-1:0] prescalerCount,
    output logic opDone
);

    if (TICK_CYC < 1 || TICK_CYC >= (1 << TICK_W)) begin : g_bad_tick
        $error("tick divide does not fit its counter");
    end
    if (PRESC_W < 1 || WDOG_W < 1 || PRESC_W > BUS_DW || WDOG_W > BUS_DW) begin : g_bad_width
        $error("counter width out of range");
    end

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

    logic [DATA_W-1:0] accum_q, accum_d;
    logic zero_q, zero_d;
    logic carry_q, carry_d;
    logic fileWr_q, fileWr_d;
    logic [FILE_ADDR_W-1:0] fileWaddr_q, fileWaddr_d;
    logic [DATA_W-1:0] fileWdata_q, fileWdata_d;
    logic opDone_q, opDone_d;
    logic psa_q, psa_d;
    logic wden_q, wden_d;
    logic [BUS_DW-1:0] rdata_q, rdata_d;
    logic [TICK_W-1:0] tickCnt_q, tickCnt_d;
    logic [PRESC_W-1:0] presc_q, presc_d;
    logic [WDOG_W-1:0] wdog_q, wdog_d;
    logic to_q, to_d;
    logic pwrdn_q, pwrdn_d;

    logic [DATA_W-1:0] bcdResult;
    logic bcdCarry;
    logic [DATA_W-1:0] compResult;
    logic doWdClear;
    logic tick;
    logic wdStep;

    ccb_bcd_adjust i_ccb_bcd_adjust (
        .value(accum_q),
        .carryIn(carry_q),
        .halfCarryIn(halfCarry),
        .result(bcdResult),
        .carryOut(bcdCarry)
    );

    assign compResult = ~fileRdata;
    assign doWdClear = opValid && (opCode == OP_WATCHDOG_CLEAR);

    // instruction execution and register bus
    always_comb begin
        accum_d = accum_q;
        zero_d = zero_q;
        carry_d = carry_q;
        psa_d = psa_q;
        wden_d = wden_q;
        fileWr_d = 1'b0;
        fileWaddr_d = fileWaddr_q;
        fileWdata_d = fileWdata_q;
        opDone_d = opValid;
        rdata_d = '0;
        // software writes first, so an instruction in the same cycle wins
        if (regWr) begin
            if (regAddr == REG_CTRL) begin
                psa_d = regWdata[CTRL_PSA_BIT];
                wden_d = regWdata[CTRL_WDEN_BIT];
            end else if (regAddr == REG_STAT) begin
                zero_d = regWdata[STAT_ZERO_BIT];
                carry_d = regWdata[STAT_CARRY_BIT];
            end else if (regAddr == REG_ACCUM) begin
                accum_d = regWdata[DATA_W-1:0];
            end
        end
        if (regRd) begin
            if (regAddr == REG_CTRL) begin
                rdata_d[CTRL_PSA_BIT] = psa_q;
                rdata_d[CTRL_WDEN_BIT] = wden_q;
            end else if (regAddr == REG_STAT) begin
                rdata_d[STAT_ZERO_BIT] = zero_q;
                rdata_d[STAT_CARRY_BIT] = carry_q;
                rdata_d[STAT_PWRDN_BIT] = pwrdn_q;
                rdata_d[STAT_TO_BIT] = to_q;
            end else if (regAddr == REG_ACCUM) begin
                rdata_d[DATA_W-1:0] = accum_q;
            end else if (regAddr == REG_WDOG) begin
                rdata_d[WDOG_W-1:0] = wdog_q;
            end else if (regAddr == REG_PRESC) begin
                rdata_d[PRESC_W-1:0] = presc_q;
            end
        end
        if (opValid) begin
            case (opCode)
                OP_CLEAR_ACCUM: begin
                    accum_d = BYTE_ZERO;
                    zero_d = 1'b1;
                end
                OP_CLEAR_REG: begin
                    fileWr_d = 1'b1;
                    fileWaddr_d = fileAddr;
                    fileWdata_d = BYTE_ZERO;
                    zero_d = 1'b1;
                end
                OP_COMPLEMENT_REG: begin
                    zero_d = (compResult == BYTE_ZERO);
                    if (destSel == DEST_FILE) begin
                        fileWr_d = 1'b1;
                        fileWaddr_d = fileAddr;
                        fileWdata_d = compResult;
                    end else begin
                        accum_d = compResult;
                    end
                end
                OP_DECIMAL_ADJUST: begin
                    accum_d = bcdResult;
                    carry_d = bcdCarry;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            accum_q <= BYTE_ZERO;
            zero_q <= 1'b0;
            carry_q <= 1'b0;
            psa_q <= CTRL_PSA_RST;
            wden_q <= CTRL_WDEN_RST;
            fileWr_q <= 1'b0;
            fileWaddr_q <= '0;
            fileWdata_q <= BYTE_ZERO;
            opDone_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            accum_q <= accum_d;
            zero_q <= zero_d;
            carry_q <= carry_d;
            psa_q <= psa_d;
            wden_q <= wden_d;
            fileWr_q <= fileWr_d;
            fileWaddr_q <= fileWaddr_d;
            fileWdata_q <= fileWdata_d;
            opDone_q <= opDone_d;
            rdata_q <= rdata_d;
        end
    end

    // watchdog, its prescaler and the flags it owns
    always_comb begin
        tick = (tickCnt_q == TICK_LAST);
        tickCnt_d = tick ? '0 : tickCnt_q + 1'b1;
        // with the prescaler on the timer side it is not ours to move
        wdStep = wden_q && tick && (!psa_q || (presc_q == '1));
        presc_d = presc_q;
        wdog_d = wdog_q;
        to_d = to_q;
        pwrdn_d = pwrdn_q;
        if (wden_q && tick && psa_q) begin
            presc_d = presc_q + 1'b1;
        end
        if (wdStep) begin
            wdog_d = wdog_q + 1'b1;
            if (wdog_q == '1) begin
                to_d = 1'b0;
            end
        end
        if (doWdClear) begin
            wdog_d = '0;
            if (psa_q) begin
                presc_d = '0;
            end
            to_d = 1'b1;
            pwrdn_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tickCnt_q <= '0;
            presc_q <= '0;
            wdog_q <= '0;
            to_q <= TO_RST;
            pwrdn_q <= PWRDN_RST;
        end else begin
            tickCnt_q <= tickCnt_d;
            presc_q <= presc_d;
            wdog_q <= wdog_d;
            to_q <= to_d;
            pwrdn_q <= pwrdn_d;
        end
    end

    assign regRdata = rdata_q;
    assign fileWrEn = fileWr_q;
    assign fileWaddr = fileWaddr_q;
    assign fileWdata = fileWdata_q;
    assign accumulator = accum_q;
    assign zeroFlag = zero_q;
    assign carryFlag = carry_q;
    assign timeoutFlag = to_q;
    assign powerdownFlag = pwrdn_q;
    assign watchdogCount = wdog_q;
    assign prescalerCount = presc_q;
    assign opDone = opDone_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_CLEAR_ACCUM: assert property (
        opValid && opCode == OP_CLEAR_ACCUM
            |=> accumulator == BYTE_ZERO && zeroFlag && !fileWrEn)
        else $error("clear accumulator did not give zero accumulator and zero flag");

    AST_CLEAR_REG: assert property (
        opValid && opCode == OP_CLEAR_REG |=> fileWrEn && fileWdata == BYTE_ZERO
            && fileWaddr == $past(fileAddr) && zeroFlag)
        else $error("clear register did not write zero to the addressed file register");

    AST_WDOG_CLEAR: assert property (
        doWdClear |=> watchdogCount == '0)
        else $error("watchdog counter not cleared");

    AST_PRESC_CLEAR: assert property (
        doWdClear && psa_q |=> prescalerCount == '0)
        else $error("prescaler not cleared while serving watchdog");

    AST_PRESC_KEEP: assert property (
        doWdClear && !psa_q |=> $stable(prescalerCount))
        else $error("prescaler disturbed while serving the timer");

    AST_TO_PD_SET: assert property (
        doWdClear |=> timeoutFlag && powerdownFlag && $stable(zeroFlag) && $stable(carryFlag))
        else $error("watchdog clear flags wrong");

    AST_COMP_ZERO: assert property (
        opValid && opCode == OP_COMPLEMENT_REG |=> zeroFlag == ($past(fileRdata) == BYTE_ONES))
        else $error("complement zero flag wrong");

    AST_COMP_ACCUM: assert property (
        opValid && opCode == OP_COMPLEMENT_REG && destSel == DEST_ACCUM
            |=> accumulator == ~$past(fileRdata) && !fileWrEn)
        else $error("complement to accumulator wrong");

    AST_COMP_FILE: assert property (
        opValid && opCode == OP_COMPLEMENT_REG && destSel == DEST_FILE
            |=> fileWrEn && fileWdata == ~$past(fileRdata) && $stable(accumulator))
        else $error("complement to file register wrong");

    AST_DECIMAL_CARRY: assert property (
        opValid && opCode == OP_DECIMAL_ADJUST
            |=> carryFlag == ($past(carryFlag) || $past(accumulator) > BCD_BYTE_MAX)
            && accumulator[3:0] <= BCD_DIGIT_MAX)
        else $error("decimal adjust result or carry wrong");

    AST_ONE_CYCLE: assert property (
        opValid |=> opDone ##1 (opDone == $past(opValid)))
        else $error("instruction did not complete in one cycle");

    COV_WDOG_PRESC: cover property (doWdClear && psa_q ##1 prescalerCount == '0);
    COV_COMP_FILE: cover property (opValid && opCode == OP_COMPLEMENT_REG && destSel);
    COV_DECIMAL_CARRY: cover property (opValid && opCode == OP_DECIMAL_ADJUST ##1 carryFlag);
    COV_TIMEOUT: cover property ($fell(timeoutFlag));

endmodule

// ---- tb/ccb_decoder_model.sv ----
`timescale 1ns/1ps
module ccb_decoder_model import ccb_pkg::*; (
    // clock
    input wire logic clk,
    // read port
    input wire logic [FILE_ADDR_W-1:0] fileAddr,
    output logic [DATA_W-1:0] fileRdata,
    // write port
    input wire logic fileWrEn,
    input wire logic [FILE_ADDR_W-1:0] fileWaddr,
    input wire logic [DATA_W-1:0] fileWdata
);
    logic [DATA_W-1:0] mem [64];
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = BYTE_ZERO;
        end
    end
    // combinational read: operand must sit beside opValid
    assign fileRdata = mem[fileAddr];
    always @(posedge clk) begin
        if (fileWrEn === 1'b1) begin
            mem[fileWaddr] <= fileWdata;
        end
    end
endmodule

// ---- tb/clear_complement_bcd_ops_tb_top.sv ----
`timescale 1ns/1ps
module clear_complement_bcd_ops_tb_top import ccb_pkg::*; ();
    logic clk, resetn, opValid, destSel, halfCarry, regWr, regRd;
    ccb_op_e opCode;
    logic [5:0] fileAddr, fileWaddr;
    logic [7:0] fileRdata, fileWdata, regAddr, accumulator, watchdogCount, prescalerCount;
    logic [31:0] regWdata, regRdata, rdv;
    logic fileWrEn, zeroFlag, carryFlag, timeoutFlag, powerdownFlag, opDone;
    int badCount, checks;

    ccb_exec #(.TICK_CYC(2)) i_ccb_exec (.clk(clk), .resetn(resetn), .opValid(opValid),
        .opCode(opCode), .fileAddr(fileAddr), .destSel(destSel), .fileRdata(fileRdata),
        .halfCarry(halfCarry), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .fileWrEn(fileWrEn), .fileWaddr(fileWaddr),
        .fileWdata(fileWdata), .accumulator(accumulator), .zeroFlag(zeroFlag),
        .carryFlag(carryFlag), .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag),
        .watchdogCount(watchdogCount), .prescalerCount(prescalerCount), .opDone(opDone));
    ccb_decoder_model i_ccb_decoder_model (.clk(clk), .fileAddr(fileAddr),
        .fileRdata(fileRdata), .fileWrEn(fileWrEn), .fileWaddr(fileWaddr),
        .fileWdata(fileWdata));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            badCount++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rdv = regRdata;
    endtask
    // results are sampled 1 ns after the edge that takes the instruction
    task automatic op(input ccb_op_e c, input logic [5:0] a, input logic d, input logic h);
        @(posedge clk);
        opValid <= 1'b1;
        opCode <= c;
        fileAddr <= a;
        destSel <= d;
        halfCarry <= h;
        @(posedge clk);
        opValid <= 1'b0;
        opCode <= OP_NONE;
        #1 chk("opDone", 1, opDone);
    endtask
    task automatic t_reset();
        #1 chk("timeout", 1, timeoutFlag);
        chk("pwrdn", 1, powerdownFlag);
        rd(REG_STAT);
        chk("stat", 32'h18, rdv);
        rd(8'h20);
        chk("unmapped", 0, rdv);
        rd(REG_CTRL);
        chk("ctrl", 32'h3, rdv);
    endtask
    task automatic t_clear_accum();
        wr(REG_ACCUM, 32'h5A);
        wr(REG_STAT, 32'h0);
        op(OP_CLEAR_ACCUM, 6'h00, 1'b0, 1'b0);
        chk("accum", 8'h00, accumulator);
        chk("zero", 1, zeroFlag);
        rd(REG_ACCUM);
        chk("accum rd", 0, rdv);
    endtask
    task automatic t_clear_reg();
        i_ccb_decoder_model.mem[63] = 8'hAB;
        wr(REG_STAT, 32'h0);
        op(OP_CLEAR_REG, 6'h3F, 1'b0, 1'b0);
        chk("wren", 1, fileWrEn);
        chk("waddr", 6'h3F, fileWaddr);
        chk("wdata", 8'h00, fileWdata);
        chk("zero", 1, zeroFlag);
        @(posedge clk);
        #1 chk("wren off", 0, fileWrEn);
        chk("mem", 8'h00, i_ccb_decoder_model.mem[63]);
    endtask
    task automatic t_complement();
        i_ccb_decoder_model.mem[5] = 8'hFF;
        i_ccb_decoder_model.mem[6] = 8'h0F;
        wr(REG_ACCUM, 32'h77);
        op(OP_COMPLEMENT_REG, 6'h05, DEST_ACCUM, 1'b0);
        chk("accum", 8'h00, accumulator);
        chk("zero", 1, zeroFlag);
        chk("wren", 0, fileWrEn);
        op(OP_COMPLEMENT_REG, 6'h06, DEST_FILE, 1'b0);
        chk("wren", 1, fileWrEn);
        chk("waddr", 6'h06, fileWaddr);
        chk("wdata", 8'hF0, fileWdata);
        chk("zero", 0, zeroFlag);
        chk("accum kept", 8'h00, accumulator);
        @(posedge clk);
        #1 chk("mem", 8'hF0, i_ccb_decoder_model.mem[6]);
    endtask
    task automatic t_watchdog();
        logic [7:0] p;
        wr(REG_STAT, 32'h3);
        repeat (40) @(posedge clk);
        op(OP_WATCHDOG_CLEAR, 6'h00, 1'b0, 1'b0);
        chk("wdog", 0, watchdogCount);
        chk("presc", 0, prescalerCount);
        chk("zero", 1, zeroFlag);
        chk("carry", 1, carryFlag);
        // prescaler to timer: watchdog now steps every tick and overflows
        wr(REG_CTRL, 32'h2);
        repeat (600) @(posedge clk);
        #1 chk("to ovf", 0, timeoutFlag);
        p = prescalerCount;
        op(OP_WATCHDOG_CLEAR, 6'h00, 1'b0, 1'b0);
        chk("presc kept", p, prescalerCount);
        chk("wdog", 0, watchdogCount);
        chk("timeout", 1, timeoutFlag);
        chk("pwrdn", 1, powerdownFlag);
        // watchdog disabled: counter must hold
        wr(REG_CTRL, 32'h0);
        #1 p = watchdogCount;
        repeat (20) @(posedge clk);
        #1 chk("wdog held", p, watchdogCount);
    endtask
    task automatic t_decimal();
        // {carry, half carry, sum} left by a decimal add, and the {carry, value} it must become
        logic [9:0] tv [5] = '{10'h09A, 10'h112, 10'h220, 10'h033, 10'h332};
        logic [8:0] ev [5] = '{9'h100, 9'h018, 9'h180, 9'h033, 9'h198};
        for (int i = 0; i < 5; i++) begin
            wr(REG_ACCUM, 32'(tv[i][7:0]));
            wr(REG_STAT, 32'(tv[i][9]) << STAT_CARRY_BIT);
            op(OP_DECIMAL_ADJUST, 6'h00, 1'b0, tv[i][8]);
            chk("decimal value", 32'(ev[i][7:0]), accumulator);
            chk("decimal carry", 32'(ev[i][8]), carryFlag);
        end
    endtask

    task automatic results();
        if (badCount == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        resetn = 1'b0;
        opValid = 1'b0;
        opCode = OP_NONE;
        fileAddr = 6'h00;
        destSel = 1'b0;
        halfCarry = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        badCount = 0;
        checks = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_clear_accum();
        t_clear_reg();
        t_complement();
        t_watchdog();
        t_decimal();
        results();
    end
    initial begin
        #100000;
        badCount++;
        results();
    end
endmodule
